// [hdl/iepb_bank.sv]
// interrupt enable and priority bank, top level
// assumes synchronous request pulses and an ahb-lite master on one clock
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module iepb_bank #(
   parameter int N_EN_REGS   = 6,
   parameter int N_PRIO_REGS = 3
) (
   input  wire logic                          hclk,
   input  wire logic                          hresetn,
   input  wire logic                          ce,
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic                          hready,
   input  wire logic [31:0]                   hwdata,
   output logic [31:0]                        hrdata,
   output logic                               hreadyout,
   output logic                               hresp,
   input  wire logic [iepb_pkg::EN_SRCS-1:0]  src_req,
   input  wire logic [iepb_pkg::PRIO_SRCS-1:0] prio_src_pend,
   output logic [iepb_pkg::EN_SRCS-1:0]       en_pending,
   output logic [iepb_pkg::PRIO_SRCS-1:0]     prio_present,
   output logic                               irq_valid,
   output logic [2:0]                         irq_level
);
   import iepb_pkg::*;

   if (N_EN_REGS != EN_REGS || N_PRIO_REGS != PRIO_REGS) begin : g_chk
      $error("iepb_bank: register counts are fixed by the bit map");
   end

   // =====================================================================
   // storage
   logic [EN_REGS-1:0][REG_W-1:0]   enable;
   logic [EN_REGS-1:0][REG_W-1:0]   flag;
   logic [PRIO_REGS-1:0][REG_W-1:0] prio;
   iepb_wr_t                        wr;
   logic [IDX_W-1:0]                rd_idx;
   logic [REG_W-1:0]                rd_data;
   logic [PRIO_SRCS*LVL_W-1:0]      prio_fields;

   // =====================================================================
   // bus port
   iepb_ahb_port u_port (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .ce        (ce),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hready    (hready),
      .hwdata    (hwdata),
      .rd_data   (rd_data),
      .rd_idx    (rd_idx),
      .wr        (wr),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp)
   );

   // =====================================================================
   // enable, flag and priority registers
   for (genvar r = 0; r < EN_REGS; r++) begin : g_en
      localparam logic [IDX_W-1:0] EN_IDX   = IDX_W'(IDX_EN0 + r);
      localparam logic [IDX_W-1:0] FLAG_IDX = IDX_W'(IDX_FLAG0 + r);

      // bit positions of every source live in EN_MASK
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            enable[r] <= EN_RST & EN_MASK[r];
         end else if (ce && wr.valid && wr.idx == EN_IDX) begin
            enable[r] <= wr.data & EN_MASK[r];
         end
      end

      // a request in the cycle of a software clear still sets the flag
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            flag[r] <= '0;
         end else if (ce) begin
            if (wr.valid && wr.idx == FLAG_IDX) begin
               flag[r] <= (wr.data | src_req[r*REG_W +: REG_W]) & EN_MASK[r];
            end else begin
               flag[r] <= (flag[r] | src_req[r*REG_W +: REG_W]) & EN_MASK[r];
            end
         end
      end

      // flag and enable together hand the source on
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            en_pending[r*REG_W +: REG_W] <= '0;
         end else if (ce) begin
            en_pending[r*REG_W +: REG_W] <= flag[r] & enable[r];
         end
      end
   end

   for (genvar p = 0; p < PRIO_REGS; p++) begin : g_prio
      localparam logic [IDX_W-1:0] P_IDX = IDX_W'(IDX_PRIO0 + p);

      // field layout 14-12, 10-8, 6-4, 2-0
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            prio[p] <= PRIO_RST & PRIO_MASK[p];
         end else if (ce && wr.valid && wr.idx == P_IDX) begin
            prio[p] <= wr.data & PRIO_MASK[p];
         end
      end

      for (genvar f = 0; f < FIELDS; f++) begin : g_fld
         assign prio_fields[(p*FIELDS+f)*LVL_W +: LVL_W] =
            prio[p][f*FIELD_STEP +: LVL_W];
      end
   end

   // =====================================================================
   // read mux; unmapped words read zero
   always_comb begin
      rd_data = '0;
      if (rd_idx < IDX_PRIO0) begin
         rd_data = enable[rd_idx[2:0]];
      end else if (rd_idx < IDX_FLAG0) begin
         rd_data = prio[2'(rd_idx - IDX_PRIO0)];
      end else if (rd_idx < IDX_W'(IDX_FLAG0 + EN_REGS)) begin
         rd_data = flag[3'(rd_idx - IDX_FLAG0)];
      end else if (rd_idx == IDX_STATUS) begin
         rd_data = {12'h000, irq_valid, irq_level};
      end
   end

   // =====================================================================
   // priority sources toward the cpu's arbitration
   iepb_prio_gate #(
      .N (PRIO_SRCS)
   ) u_gate (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .ce        (ce),
      .req       (prio_src_pend),
      .prio      (prio_fields),
      .present   (prio_present),
      .irq_valid (irq_valid),
      .irq_level (irq_level)
   );

endmodule
`default_nettype wire

// [hdl/iepb_pkg.sv]
// package for the interrupt enable and priority bank
// assumes one system clock; register map is word aligned on an AHB-Lite slave
package iepb_pkg;

   // =====================================================================
   // geometry
   localparam int EN_REGS   = 6;
   localparam int PRIO_REGS = 3;
   localparam int FIELDS    = 4;
   localparam int LVL_W     = 3;
   localparam int REG_W     = 16;
   localparam int IDX_W     = 4;
   localparam int PRIO_SRCS = PRIO_REGS * FIELDS;
   localparam int EN_SRCS   = EN_REGS * REG_W;

   // =====================================================================
   // word indices; byte address is index times four
   localparam logic [IDX_W-1:0] IDX_EN0    = 4'h0;
   localparam logic [IDX_W-1:0] IDX_PRIO0  = 4'h6;
   localparam logic [IDX_W-1:0] IDX_FLAG0  = 4'h9;
   localparam logic [IDX_W-1:0] IDX_STATUS = 4'hf;
   localparam int               ADDR_LSB   = 2;
   localparam logic [7:0]       ADDR_SPAN  = 8'h40;

   // =====================================================================
   // implemented bits, entry 0 is irq_enable_ctrl_1, then 3, 4, 5, 6, 7
   localparam logic [EN_REGS-1:0][REG_W-1:0] EN_MASK = {
      16'h001f,   // irq_enable_ctrl_7: adc pairs 6..2
      16'hc383,   // irq_enable_ctrl_6
      16'hc001,   // irq_enable_ctrl_5
      16'h0002,   // irq_enable_ctrl_4
      16'h0200,   // irq_enable_ctrl_3
      16'h201f};  // irq_enable_ctrl_1
   localparam logic [REG_W-1:0] EN_RST = 16'h0000;

   // entry 0 is irq_priority_ctrl_0
   localparam logic [PRIO_REGS-1:0][REG_W-1:0] PRIO_MASK = {
      16'h7777,
      16'h7770,
      16'h7777};
   localparam logic [REG_W-1:0] PRIO_RST   = 16'h4444;
   localparam int               FIELD_STEP = 4;
   localparam logic [LVL_W-1:0] PRIO_OFF   = 3'h0;

   // =====================================================================
   // bus encodings
   localparam logic [1:0] HTRANS_IDLE   = 2'h0;
   localparam logic       HRESP_OKAY    = 1'h0;

   typedef struct packed {
      logic             valid;
      logic [IDX_W-1:0] idx;
      logic [REG_W-1:0] data;
   } iepb_wr_t;

endpackage

// [hdl/iepb_ahb_port.sv]
// ahb-lite slave front end of the interrupt bank
// assumes hready is the bus ready; zero wait states, every response okay
`timescale 1ns/100ps
`default_nettype none
module iepb_ahb_port (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               ce,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic               hready,
   input  wire logic [31:0]        hwdata,
   input  wire logic [15:0]        rd_data,
   output logic [3:0]              rd_idx,
   output iepb_pkg::iepb_wr_t      wr,
   output logic [31:0]             hrdata,
   output logic                    hreadyout,
   output logic                    hresp
);
   import iepb_pkg::*;

   logic             take;
   logic             mapped;
   logic             wr_pend;
   logic [IDX_W-1:0] wr_idx;

   // =====================================================================
   // address phase decode
   assign take   = hsel && hready && (htrans[1] != HTRANS_IDLE[1]);
   assign mapped = (haddr[31:0] < {24'h000000, ADDR_SPAN}) && (hsize == 3'h2);
   assign rd_idx = haddr[ADDR_LSB +: IDX_W];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx  <= IDX_EN0;
      end else if (ce) begin
         wr_pend <= take && hwrite && mapped;
         wr_idx  <= rd_idx;
      end
   end

   // read data is sampled in the address phase so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (ce && take) begin
         hrdata <= (!hwrite && mapped) ? {16'h0000, rd_data} : 32'h00000000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end
   end

   assign wr.valid = wr_pend && ce;
   assign wr.idx   = wr_idx;
   assign wr.data  = hwdata[REG_W-1:0];

endmodule
`default_nettype wire

// [hdl/iepb_prio_gate.sv]
// per-source priority gate and highest-level pick for the cpu
// assumes pending requests arrive already masked by their enables
`timescale 1ns/100ps
`default_nettype none
module iepb_prio_gate #(
   parameter int N = 12
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             ce,
   input  wire logic [N-1:0]     req,
   input  wire logic [N*3-1:0]   prio,
   output logic [N-1:0]          present,
   output logic                  irq_valid,
   output logic [2:0]            irq_level
);
   import iepb_pkg::*;

   logic [N-1:0]       next_present;
   logic [LVL_W-1:0]   next_level;

   if (N < 1) begin : g_chk
      $error("iepb_prio_gate needs at least one source");
   end

   // =====================================================================
   // gating per source
   for (genvar i = 0; i < N; i++) begin : g_src
      // a zero field blocks the source whatever its enable holds
      assign next_present[i] = req[i] && (prio[i*LVL_W +: LVL_W] != PRIO_OFF);
   end

   // higher code wins, 7 highest and 1 lowest
   always_comb begin
      next_level = PRIO_OFF;
      for (int k = 0; k < N; k++) begin
         if (next_present[k] && (prio[k*LVL_W +: LVL_W] > next_level)) begin
            next_level = prio[k*LVL_W +: LVL_W];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         present   <= '0;
         irq_valid <= 1'b0;
         irq_level <= PRIO_OFF;
      end else if (ce) begin
         present   <= next_present;
         irq_valid <= |next_present;
         irq_level <= next_level;
      end
   end

endmodule
`default_nettype wire

// [testbench/iepb_bank_monitor.sv]
// port checker for the interrupt enable and priority bank
// assumes it is bound onto iepb_bank, one clock, pending inputs steady while ce is low
`timescale 1ns/100ps
`default_nettype none
module iepb_bank_monitor
   import iepb_pkg::*;
(
   input wire logic                 hclk,
   input wire logic                 hresetn,
   input wire logic                 hsel,
   input wire logic [1:0]           htrans,
   input wire logic                 hready,
   input wire logic [31:0]          hrdata,
   input wire logic                 hreadyout,
   input wire logic                 hresp,
   input wire logic [PRIO_SRCS-1:0] prio_src_pend,
   input wire logic [EN_SRCS-1:0]   en_pending,
   input wire logic [PRIO_SRCS-1:0] prio_present,
   input wire logic                 irq_valid,
   input wire logic [2:0]           irq_level
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // =================================================================
   // sequences
   sequence s_bus_quiet;
      !(hsel && htrans[1] && hready);
   endsequence
   sequence s_data_kept;
      ##1 $stable(hrdata);
   endsequence
   // =================================================================
   // assertions
   AST_READY: assert property (hreadyout)
      else $error("hreadyout low");
   AST_OKAY: assert property (hresp == HRESP_OKAY)
      else $error("hresp not okay");
   AST_UPPER: assert property (hrdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   AST_RD_HOLD: assert property (s_bus_quiet |-> s_data_kept)
      else $error("hrdata moved without a transfer");
   AST_PRES: assert property ((prio_present & ~$past(prio_src_pend)) == '0)
      else $error("source presented without pending request");
   AST_VALID: assert property (irq_valid == (|prio_present))
      else $error("irq_valid disagrees with presented set");
   AST_LEVEL0: assert property (!irq_valid |-> irq_level == 3'h0)
      else $error("level without request");
   AST_LEVEL_NZ: assert property (irq_valid |-> irq_level != PRIO_OFF)
      else $error("request at disabled level");
   AST_PEND_MASK: assert property ((en_pending & ~EN_MASK) == '0)
      else $error("pending on unimplemented position");
endmodule
bind iepb_bank iepb_bank_monitor i_mon (.hclk, .hresetn, .hsel, .htrans, .hready,
   .hrdata, .hreadyout, .hresp, .prio_src_pend, .en_pending, .prio_present,
   .irq_valid, .irq_level);
`default_nettype wire

// [testbench/iepb_src_model.sv]
// peripheral request sources facing the bank
// assumes commands from the bench change just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module iepb_src_model
   import iepb_pkg::*;
(
   input wire logic                  hclk,
   input wire logic                  fire,
   input wire logic [6:0]            fire_bit,
   input wire logic [PRIO_SRCS-1:0]  pend_in,
   output logic [EN_SRCS-1:0]        src_req,
   output logic [PRIO_SRCS-1:0]      prio_src_pend
);
   // one-cycle request pulse, so a flag must latch it to be seen later
   always_ff @(posedge hclk) begin
      src_req <= fire ? (EN_SRCS'(1) << fire_bit) : '0;
      prio_src_pend <= pend_in;
   end
endmodule
`default_nettype wire

// [testbench/iepb_bank_bench.sv]
// self-checking bench for the interrupt enable and priority bank
// assumes the source model and the bound port checker
`timescale 1ns/100ps
`default_nettype none
module iepb_bank_bench;
   import iepb_pkg::*;
   logic                 hclk, hresetn, hsel, hwrite, rd_ph, fire, ce;
   logic [1:0]           htrans;
   logic [2:0]           hsize, irq_level;
   logic [31:0]          haddr, hwdata, hrdata, rnd, exp_q[$];
   logic                 hreadyout, hresp, irq_valid;
   logic [6:0]           fire_bit;
   logic [PRIO_SRCS-1:0] pend_in, prio_src_pend, prio_present;
   logic [EN_SRCS-1:0]   src_req, en_pending;
   logic [11:0]          pend_tab[4] = '{12'hfff, 12'h002, 12'h001, 12'h004};
   logic [31:0]          stat_tab[4] = '{32'hf, 32'hb, 32'h9, 32'h0};
   int                   n_mismatch, num_checks, seed, j;
   wire                  hready = hreadyout;

   iepb_bank i_dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .src_req, .prio_src_pend,
      .en_pending, .prio_present, .irq_valid, .irq_level);
   iepb_src_model i_src (.hclk, .fire, .fire_bit, .pend_in, .src_req, .prio_src_pend);

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   // =================================================================
   // checking and closing
   task automatic check(input string nm, input logic [95:0] seen, input logic [95:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   function automatic logic [31:0] reg_exp(input int r, input logic [15:0] v);
      return {16'h0, v & ((r < 6) ? EN_MASK[r] : PRIO_MASK[r-6])};
   endfunction
   always @(posedge hclk) begin
      if (rd_ph === 1'b1 && hready === 1'b1)
         check("hrdata", hrdata, exp_q.pop_front());
   end
   // =================================================================
   // ahb-lite master, one single word transfer at a time
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         n_mismatch++;
         stop_test;
      end
   endtask
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy;
      htrans <= HTRANS_IDLE;
      hsel <= 1'b0;
      hwdata <= d;
      rd_ph <= !w;
      wait_rdy;
      rd_ph <= 1'b0;
   endtask
   task rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask
   task pulse(input logic [6:0] b);
      @(posedge hclk);
      fire <= 1'b1;
      fire_bit <= b;
      @(posedge hclk);
      fire <= 1'b0;
   endtask
   // =================================================================
   // main sequence
   initial begin
      hresetn = 1'b0;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rd_ph = 1'b0;
      fire = 1'b0;
      fire_bit = 7'h0;
      pend_in = '0;
      seed = 32'h06a5f315;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      for (j = 0; j < 9; j++)
         rd(j * 4, reg_exp(j, (j < 6) ? EN_RST : PRIO_RST));
      // all ones shows the implemented map, random words show read/write
      for (j = 0; j < 9; j++) begin
         rnd = $random(seed);
         xfer(1'b1, j * 4, 32'hffffffff);
         rd(j * 4, reg_exp(j, 16'hffff));
         xfer(1'b1, j * 4, rnd);
         rd(j * 4, reg_exp(j, rnd[15:0]));
      end
      xfer(1'b1, 32'h40, 32'hffff);
      rd(32'h40, 32'h0);
      // request on an enabled source and on an empty position next to it
      xfer(1'b1, 32'h4, 32'h0200);
      pulse(7'd25);
      pulse(7'd24);
      repeat (4) @(posedge hclk);
      check("en_pending", en_pending, 96'h1 << 25);
      rd(32'h28, 32'h0200);
      xfer(1'b1, 32'h4, 32'h0);
      repeat (3) @(posedge hclk);
      check("en_pending", en_pending, 96'h0);
      rd(32'h28, 32'h0200);
      xfer(1'b1, 32'h28, 32'h0);
      rd(32'h28, 32'h0);
      // clock enable low freezes the flags, so the request is lost
      ce <= 1'b0;
      pulse(7'd25);
      repeat (2) @(posedge hclk);
      ce <= 1'b1;
      rd(32'h28, 32'h0);
      // levels 7, 3, 1 and a disabled field on the first priority word
      xfer(1'b1, 32'h18, 32'h7031);
      xfer(1'b1, 32'h1c, 32'h0);
      xfer(1'b1, 32'h20, 32'h0);
      for (j = 0; j < 4; j++) begin
         @(posedge hclk);
         pend_in <= pend_tab[j];
         repeat (3) @(posedge hclk);
         check("prio_present", prio_present, pend_tab[j] & 12'h00b);
         rd(32'h3c, stat_tab[j]);
      end
      stop_test;
   end
endmodule
`default_nettype wire
